// ### irtc_pkg.sv
// Package for the infrared transceiver configuration block.
// Assumes a 200 MHz core clock and an AHB-Lite register bus of 32-bit words.
package irtc_pkg;

  // Printed register indexes; the byte address is four times the index
  localparam logic [7:0] IRTC_IDX_RC_CFG = 8'h02;
  localparam logic [7:0] IRTC_IDX_LINK_CONTROL_BANK_SELECT_ALIAS = 8'h03;
  localparam logic [7:0] IRTC_IDX_CFG_ONE = 8'h04;
  localparam logic [7:0] IRTC_IDX_RSVD = 8'h05;
  localparam logic [7:0] IRTC_IDX_CFG_THREE = 8'h06;
  localparam logic [7:0] IRTC_IDX_CFG_FOUR = 8'h07;
  // Extra register for mode inputs (own choice)
  localparam logic [7:0] IRTC_IDX_MODE = 8'h08;

  // Consumer-IR config field positions
  localparam int IRTC_RC_TXHS_BIT = 2;
  localparam int IRTC_RC_DMDS_BIT = 4;
  localparam int IRTC_RC_RXHS_BIT = 5;
  localparam int IRTC_RC_OVS_BIT = 6;
  localparam int IRTC_RC_RLEN_BIT = 7;
  localparam logic [7:0] IRTC_RC_MASK = 8'hF7;
  // Config one fields
  localparam int IRTC_C1_FTX_BIT = 7;
  localparam int IRTC_C1_SIR_LSB = 4;
  // Config three writable bits
  localparam logic [7:0] IRTC_C3_MASK = 8'h77;
  // Config four fields
  localparam int IRTC_C4_HIDIR_BIT = 3;
  localparam int IRTC_C4_RECEIVE_INVERT_BIT = 4;
  localparam int IRTC_C4_DIR0_BIT = 5;
  localparam int IRTC_C4_AUTO_BIT = 7;
  localparam logic [7:0] IRTC_C4_MASK = 8'hB8;
  // Mode register fields
  localparam int IRTC_MODE_AUX_BIT = 4;

  // Reset values
  localparam logic [7:0] IRTC_RST_RC_CFG = 8'h00;
  localparam logic [7:0] IRTC_RST_CFG_ONE = 8'h00;
  localparam logic [7:0] IRTC_RST_CFG_THREE = 8'h00;
  localparam logic [7:0] IRTC_RST_CFG_FOUR = 8'h00;
  localparam logic [7:0] IRTC_RST_LINK_CONTROL_BANK_SELECT_ALIAS = 8'h00;

  // Forced-transmit pulse timing
  localparam int IRTC_CLK_MHZ = 200;
  localparam int IRTC_FTX_US = 64;
  localparam int IRTC_FTX_CYC = IRTC_FTX_US * IRTC_CLK_MHZ;

  // Active infrared mode
  typedef enum logic [1:0] {
    IRTC_MODE_SIR,
    IRTC_MODE_KEYED,
    IRTC_MODE_CIR,
    IRTC_MODE_OTHER
  } irtc_mode_e;

  // Select/ID pin group: input, output, output enable
  typedef struct packed {
    logic [2:0] din;
    logic [2:0] dout;
    logic [2:0] oe;
  } irtc_sel_pins_s;

  // Transmit and receive path configuration handed to the transceiver
  typedef struct packed {
    logic tx_carrier_range_sel;
    logic demodulator_disable;
    logic rx_carrier_range_sel;
    logic sampling_mode_sel;
    logic run_length_enable;
  } irtc_cir_cfg_s;

endpackage : irtc_pkg

// ### irtc_top.sv
// Infrared transceiver configuration register bank with AHB-Lite slave.
// Assumes a single AHB-Lite master, synchronous pin inputs and one clock.
//
// Overview of operation
// - Bit 2 selects transmit carrier range
// - Bit 4 bypasses internal demodulator
// - Bit 5 selects receive carrier range
// - Bit 6 selects oversampling or period sampling
// - Bit 7 enables run-length byte coding
// - ID0 input: read pin, ignore writes
// - ID0 output: bit 0 drives pin
// - Bits 2-1 behave likewise for ID1, ID2
// - Bit 3 reads ID3 pin, read only
// - SIR field drives select pins automatically
// - Forced transmit pulse lasts 64 us
// - Low-range consumer-IR field drives select pins
// - High-range consumer-IR field drives select pins
// - Config three and four reset zero
// - Bit 3 sets ID1/ID2 direction
// - Receive invert bit inverts receive input
// - Bit 5 sets ID0 pin direction
// - Bit 7 enables automatic pin selection
// - Receive input chosen by direction, aux bit
// - Consumer-IR config resets to zero
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module irtc_top
  import irtc_pkg::*;
#(
  parameter int FTX_CYCLES = irtc_pkg::IRTC_FTX_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [2:0] sel_pin_in,
  output logic [2:0] sel_pin_out,
  output logic [2:0] sel_pin_oe,
  input wire logic id_pin3,
  input wire logic receive_input_one,
  output logic ir_transmit_out,
  output logic rx_data,
  output irtc_pkg::irtc_cir_cfg_s cir_cfg
);
  import irtc_pkg::*;

  // Registers
  logic [7:0] rc_cfg_r;
  logic [7:0] cfg_one_r;
  logic [7:0] cfg_three_r;
  logic [7:0] cfg_four_r;
  logic [7:0] link_control_bank_select_alias_r;
  logic [1:0] mode_r;
  logic aux_receive_select_r;
  logic [15:0] ftx_cnt_r;
  logic forced_transmit_pulse_r;

  // Address phase capture
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] idx_r;

  logic take;
  logic [7:0] idx_in;
  logic [7:0] wd;
  logic [2:0] sel_drive;
  logic [2:0] sel_dir;
  logic [2:0] id_bits_rd;
  logic [7:0] cfg_one_rd;
  logic [31:0] rd_nxt;
  logic rx_mux;
  irtc_mode_e mode_cur;
  logic ftx_set;

  assign take = hsel && hready && htrans[1];
  assign idx_in = haddr[9:2];
  assign wd = hwdata[7:0];
  assign mode_cur = irtc_mode_e'(mode_r);
  assign ftx_set = wr_pend_r && (idx_r == IRTC_IDX_CFG_ONE) && wd[IRTC_C1_FTX_BIT];

  // Direction of each select pin
  assign sel_dir = {{2{cfg_four_r[IRTC_C4_HIDIR_BIT]}}, cfg_four_r[IRTC_C4_DIR0_BIT]};

  // Data phase flags; zero wait states, so every transfer ends after one data cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r <= 8'h00;
    end else begin
      wr_pend_r <= take && hwrite;
      rd_pend_r <= take && !hwrite;
      if (take) begin
        idx_r <= idx_in;
      end
    end
  end

  // Consumer-IR config; reserved bit 3 stays zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rc_cfg_r <= IRTC_RST_RC_CFG;
    end else if (wr_pend_r && idx_r == IRTC_IDX_RC_CFG) begin
      rc_cfg_r <= wd & IRTC_RC_MASK;
    end
  end

  // Link control alias is plain storage here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_control_bank_select_alias_r <= IRTC_RST_LINK_CONTROL_BANK_SELECT_ALIAS;
    end else if (wr_pend_r && idx_r == IRTC_IDX_LINK_CONTROL_BANK_SELECT_ALIAS) begin
      link_control_bank_select_alias_r <= wd;
    end
  end

  // Config one: bits of input pins ignore writes, bit 3 is never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_one_r <= IRTC_RST_CFG_ONE;
    end else if (wr_pend_r && idx_r == IRTC_IDX_CFG_ONE) begin
      cfg_one_r[6:4] <= wd[6:4];
      cfg_one_r[3] <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        if (sel_dir[i]) begin
          cfg_one_r[i] <= wd[i];
        end
      end
      cfg_one_r[7] <= 1'b0;
    end
  end

  // Config three and four
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_three_r <= IRTC_RST_CFG_THREE;
      cfg_four_r <= IRTC_RST_CFG_FOUR;
    end else if (wr_pend_r) begin
      if (idx_r == IRTC_IDX_CFG_THREE) begin
        cfg_three_r <= wd & IRTC_C3_MASK;
      end
      if (idx_r == IRTC_IDX_CFG_FOUR) begin
        cfg_four_r <= wd & IRTC_C4_MASK;
      end
    end
  end

  // Mode register stands in for the mode and aux bits kept elsewhere in the port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= 2'h0;
      aux_receive_select_r <= 1'b0;
    end else if (wr_pend_r && idx_r == IRTC_IDX_MODE) begin
      mode_r <= wd[1:0];
      aux_receive_select_r <= wd[IRTC_MODE_AUX_BIT];
    end
  end

  // Forced transmit: a new write of 1 restarts; timeout clears the bit, and the registered output one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      forced_transmit_pulse_r <= 1'b0;
      ftx_cnt_r <= 16'h0000;
    end else if (ftx_set) begin
      forced_transmit_pulse_r <= 1'b1;
      ftx_cnt_r <= 16'(FTX_CYCLES - 1);
    end else if (forced_transmit_pulse_r) begin
      if (ftx_cnt_r == 16'h0000) begin
        forced_transmit_pulse_r <= 1'b0;
      end else begin
        ftx_cnt_r <= ftx_cnt_r - 16'h0001;
      end
    end
  end

  // Pin value chosen by auto configuration and active mode
  always_comb begin
    sel_drive = cfg_one_r[2:0];
    if (cfg_four_r[IRTC_C4_AUTO_BIT]) begin
      case (mode_cur)
        IRTC_MODE_SIR: sel_drive = cfg_one_r[6:4];
        IRTC_MODE_KEYED: sel_drive = cfg_one_r[2:0];
        IRTC_MODE_CIR: begin
          if (rc_cfg_r[IRTC_RC_RXHS_BIT]) begin
            sel_drive = cfg_three_r[6:4];
          end else begin
            sel_drive = cfg_three_r[2:0];
          end
        end
        default: sel_drive = cfg_one_r[2:0];
      endcase
    end
  end

  // Receive input selection, polarity applied at the output register; ID0 pin doubles as second receive input
  always_comb begin
    if (aux_receive_select_r) begin
      rx_mux = sel_dir[0] ? 1'b1 : sel_pin_in[0];
    end else begin
      rx_mux = receive_input_one;
    end
  end

  // Readback of config one: input pins show their levels
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      id_bits_rd[i] = sel_dir[i] ? cfg_one_r[i] : sel_pin_in[i];
    end
    cfg_one_rd = {forced_transmit_pulse_r, cfg_one_r[6:4], id_pin3, id_bits_rd};
  end

  // Read mux; unmapped and reserved words read as zero
  always_comb begin
    rd_nxt = 32'h00000000;
    if (take && !hwrite) begin
      case (idx_in)
        IRTC_IDX_RC_CFG: rd_nxt[7:0] = rc_cfg_r;
        IRTC_IDX_LINK_CONTROL_BANK_SELECT_ALIAS: rd_nxt[7:0] = link_control_bank_select_alias_r;
        IRTC_IDX_CFG_ONE: rd_nxt[7:0] = cfg_one_rd;
        IRTC_IDX_CFG_THREE: rd_nxt[7:0] = cfg_three_r;
        IRTC_IDX_CFG_FOUR: rd_nxt[7:0] = cfg_four_r;
        IRTC_IDX_MODE: rd_nxt[7:0] = {3'h0, aux_receive_select_r, 2'h0, mode_r};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // Bus outputs registered; reads sampled at the address phase edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end

  // Pin and datapath outputs registered, one cycle behind configuration; transmit output rises with the write that sets the forced bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_pin_out <= 3'h0;
      sel_pin_oe <= 3'h0;
      ir_transmit_out <= 1'b0;
      rx_data <= 1'b0;
      cir_cfg <= '0;
    end else begin
      sel_pin_out <= sel_drive;
      sel_pin_oe <= sel_dir;
      ir_transmit_out <= ftx_set || forced_transmit_pulse_r;
      rx_data <= rx_mux ^ cfg_four_r[IRTC_C4_RECEIVE_INVERT_BIT];
      cir_cfg.tx_carrier_range_sel <= rc_cfg_r[IRTC_RC_TXHS_BIT];
      cir_cfg.demodulator_disable <= rc_cfg_r[IRTC_RC_DMDS_BIT];
      cir_cfg.rx_carrier_range_sel <= rc_cfg_r[IRTC_RC_RXHS_BIT];
      cir_cfg.sampling_mode_sel <= rc_cfg_r[IRTC_RC_OVS_BIT];
      cir_cfg.run_length_enable <= rc_cfg_r[IRTC_RC_RLEN_BIT];
    end
  end

endmodule : irtc_top

// ### irtc_chk.sv
// Checker for irtc_top: shadows registers from bus writes, checks pins and pulse.
// Assumes word accesses at byte addresses below 0x400.
`timescale 1ns/1ps
module irtc_chk
  import irtc_pkg::*;
#(
  parameter int FTX_CYCLES = irtc_pkg::IRTC_FTX_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [2:0] sel_pin_in,
  input wire logic [2:0] sel_pin_out,
  input wire logic [2:0] sel_pin_oe,
  input wire logic receive_input_one,
  input wire logic ir_transmit_out,
  input wire logic rx_data,
  input wire irtc_pkg::irtc_cir_cfg_s cir_cfg
);
  logic wr_q, live_q;
  logic [7:0] wa_q, rc, c1, c3, c4, md;
  int cnt;
  wire logic [2:0] drv = sel_pin_out & sel_pin_oe;
  wire logic src = md[4] ? (c4[5] | sel_pin_in[0]) : receive_input_one;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow written at the data-phase edge, as the block does
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {wr_q, live_q, wa_q, rc, c1, c3, c4, md} <= '0;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite;
      wa_q <= haddr[9:2];
      live_q <= 1'b1;
      if (wr_q && wa_q == IRTC_IDX_RC_CFG) rc <= hwdata[7:0] & IRTC_RC_MASK;
      if (wr_q && wa_q == IRTC_IDX_CFG_THREE) c3 <= hwdata[7:0] & IRTC_C3_MASK;
      if (wr_q && wa_q == IRTC_IDX_CFG_FOUR) c4 <= hwdata[7:0] & IRTC_C4_MASK;
      if (wr_q && wa_q == IRTC_IDX_MODE) md <= hwdata[7:0];
      if (wr_q && wa_q == IRTC_IDX_CFG_ONE) begin
        c1[6:4] <= hwdata[6:4];
        if (c4[5]) c1[0] <= hwdata[0];  // Input pins drop writes
        if (c4[3]) c1[2:1] <= hwdata[2:1];
      end
    end
  end
  // Cycles since the last write of 1 to the forced bit, saturating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt <= FTX_CYCLES + 2;
    else if (wr_q && wa_q == IRTC_IDX_CFG_ONE && hwdata[7]) cnt <= 0;
    else if (cnt < FTX_CYCLES + 2) cnt <= cnt + 1;
  end
  AST_OE: assert property (live_q |-> sel_pin_oe == $past({c4[3], c4[3], c4[5]}))
    else $error("pin direction wrong");
  AST_PIN_MAN: assert property (live_q && $past(!c4[7] || md[0]) |->
    drv == ($past(c1[2:0]) & sel_pin_oe)) else $error("manual pin drive wrong");
  AST_PIN_SIR: assert property (live_q && $past(c4[7] && md[1:0] == IRTC_MODE_SIR) |->
    drv == ($past(c1[6:4]) & sel_pin_oe)) else $error("sir pin drive wrong");
  AST_PIN_CLO: assert property (
    live_q && $past(c4[7] && md[1:0] == IRTC_MODE_CIR && !rc[5]) |->
    drv == ($past(c3[2:0]) & sel_pin_oe)) else $error("cir low pin drive wrong");
  AST_PIN_CHI: assert property (
    live_q && $past(c4[7] && md[1:0] == IRTC_MODE_CIR && rc[5]) |->
    drv == ($past(c3[6:4]) & sel_pin_oe)) else $error("cir high pin drive wrong");
  AST_CIR: assert property (live_q |-> cir_cfg == $past({rc[2], rc[4], rc[5], rc[6], rc[7]}))
    else $error("cir config copy wrong");
  AST_RX: assert property (live_q |-> rx_data == $past(src ^ c4[4]))
    else $error("receive path wrong");
  AST_FTX_ON: assert property (cnt >= 1 && cnt < FTX_CYCLES |-> ir_transmit_out)
    else $error("forced pulse too short");
  AST_FTX_OFF: assert property (cnt == FTX_CYCLES + 2 |-> !ir_transmit_out)
    else $error("forced pulse too long");
endmodule : irtc_chk
bind irtc_top irtc_chk #(.FTX_CYCLES(FTX_CYCLES)) u_chk (.clk(clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .sel_pin_in(sel_pin_in), .sel_pin_out(sel_pin_out),
  .sel_pin_oe(sel_pin_oe), .receive_input_one(receive_input_one),
  .ir_transmit_out(ir_transmit_out), .rx_data(rx_data), .cir_cfg(cir_cfg));

// ### irtc_xcvr_model.sv
// Transceiver model: straps its ID levels on select pins the block does not drive.
// Assumes the block's output enables mark the pins it drives.
`timescale 1ns/1ps
module irtc_xcvr_model (
  input wire logic [2:0] sel_pin_out,
  input wire logic [2:0] sel_pin_oe,
  input wire logic [2:0] id_val,
  output logic [2:0] sel_pin_in
);
  // Wire level: block drive where enabled, else the module's strap
  assign sel_pin_in = (sel_pin_out & sel_pin_oe) | (id_val & ~sel_pin_oe);
endmodule : irtc_xcvr_model

// ### irtc_tb.sv
// Bench for irtc_top: AHB-Lite word accesses with the transceiver model on the pins.
// Assumes the block answers with zero wait states.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  import irtc_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic rx1 = 1'b0;
  logic id3 = 1'b0;
  logic [2:0] idv = 3'h0;
  logic hready, hresp, txo, rxd;
  logic [31:0] hrdata;
  logic [2:0] pin_in, pin_out, pin_oe;
  irtc_cir_cfg_s cfg;
  logic [7:0] d;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] ra [5] = '{8'h02, 8'h06, 8'h07, 8'h03, 8'h10};
  logic [7:0] rm [5] = '{8'hF7, 8'h77, 8'hB8, 8'hFF, 8'h00};
  logic [7:0] ca [3] = '{8'h04, 8'h50, 8'hA0};  // Transmit range alone; demod off with oversampling; receive range with run length
  logic [4:0] ce [3] = '{5'h10, 5'h0A, 5'h05};
  logic [7:0] va [5] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h03};
  logic [7:0] vb [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
  logic [2:0] vc [5] = '{3'h7, 3'h2, 3'h1, 3'h5, 3'h2};
  logic [7:0] xa [5] = '{8'h00, 8'h00, 8'h20, 8'h30, 8'h10};
  logic [7:0] xb [5] = '{8'h03, 8'h13, 8'h13, 8'h13, 8'h03};
  logic xc [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  irtc_top #(.FTX_CYCLES(20)) uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .sel_pin_in(pin_in),
    .sel_pin_out(pin_out), .sel_pin_oe(pin_oe), .id_pin3(id3), .receive_input_one(rx1),
    .ir_transmit_out(txo), .rx_data(rxd), .cir_cfg(cfg));
  irtc_xcvr_model xcvr (.sel_pin_out(pin_out), .sel_pin_oe(pin_oe), .id_val(idv),
    .sel_pin_in(pin_in));

  always #2.5 clk = ~clk;

  // Cycle ceiling; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict();
    end
  end

  // One single transfer, then an idle cycle so registered outputs follow a write before the checks
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    hwrite <= w;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata[7:0];
    @(posedge clk);
    @(negedge clk);
  endtask : xfer

  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 8'h00);
      `CHK("reset", 8'h00, d)
      `CHK("resp", 1'b0, hresp)
      xfer(1'b1, ra[i], 8'hFF);
      xfer(1'b0, ra[i], 8'h00);
      `CHK("mask", rm[i], d)
    end
    `CHK("cir all", 5'h1F, cfg)
    foreach (ca[i]) begin
      xfer(1'b1, IRTC_IDX_RC_CFG, ca[i]);
      `CHK("cir", ce[i], cfg)
    end
    @(posedge clk);
    idv <= 3'b101;
    id3 <= 1'b1;
    xfer(1'b1, IRTC_IDX_CFG_FOUR, 8'h00);
    xfer(1'b1, IRTC_IDX_CFG_ONE, 8'h07);
    xfer(1'b0, IRTC_IDX_CFG_ONE, 8'h00);
    `CHK("id in", 8'h0D, d)
    `CHK("oe in", 3'h0, pin_oe)
    xfer(1'b1, IRTC_IDX_CFG_FOUR, 8'h28);
    xfer(1'b1, IRTC_IDX_CFG_ONE, 8'h72);
    xfer(1'b0, IRTC_IDX_CFG_ONE, 8'h00);
    `CHK("id out", 8'h7A, d)
    `CHK("oe out", 3'h7, pin_oe)
    `CHK("pin man", 3'h2, pin_out)
    xfer(1'b1, IRTC_IDX_CFG_THREE, 8'h51);
    xfer(1'b1, IRTC_IDX_CFG_FOUR, 8'hA8);
    foreach (va[i]) begin
      xfer(1'b1, IRTC_IDX_MODE, va[i]);
      xfer(1'b1, IRTC_IDX_RC_CFG, vb[i]);
      `CHK("pin auto", vc[i], pin_out)
    end
    @(posedge clk);
    idv <= 3'b000;
    rx1 <= 1'b1;
    foreach (xa[i]) begin
      xfer(1'b1, IRTC_IDX_CFG_FOUR, xa[i]);
      xfer(1'b1, IRTC_IDX_MODE, xb[i]);
      `CHK("rx", xc[i], rxd)
    end
    // Pulse, ignored zero write, restart; restarts kept short of LED stress
    xfer(1'b1, IRTC_IDX_CFG_ONE, 8'h80);
    `CHK("ftx on", 1'b1, txo)
    xfer(1'b1, IRTC_IDX_CFG_ONE, 8'h00);
    `CHK("ftx hold", 1'b1, txo)
    xfer(1'b0, IRTC_IDX_CFG_ONE, 8'h00);
    `CHK("ftx bit on", 1'b1, d[7])
    repeat (4) @(posedge clk);
    xfer(1'b1, IRTC_IDX_CFG_ONE, 8'h80);
    repeat (16) @(posedge clk);
    @(negedge clk);
    `CHK("ftx restart", 1'b1, txo)
    repeat (8) @(posedge clk);
    xfer(1'b0, IRTC_IDX_CFG_ONE, 8'h00);
    `CHK("ftx bit", 1'b0, d[7])
    `CHK("ftx off", 1'b0, txo)
    print_verdict();
  end
endmodule : testbench
